// File: pkg/sidp_pkg.sv
// package for the subtract instruction datapath
// assumes an avalon-mm host with waitrequest and one 50 MHz clock
package sidp_pkg;

	// =========================================================
	// register map (word byte addresses)
	localparam logic [3:0] SIDP_ADDR_CMD    = 4'h0;
	localparam logic [3:0] SIDP_ADDR_WREG   = 4'h4;
	localparam logic [3:0] SIDP_ADDR_STATUS = 4'h8;
	localparam logic [3:0] SIDP_ADDR_MADDR  = 4'hC;

	// =========================================================
	// command field layout
	localparam int SIDP_CMD_OP_LSB  = 8;
	localparam int SIDP_CMD_IMM_LSB = 0;

	// =========================================================
	// status bit positions
	localparam int SIDP_ST_C   = 0;
	localparam int SIDP_ST_AC  = 1;
	localparam int SIDP_ST_Z   = 2;
	localparam int SIDP_ST_OV  = 3;
	localparam int SIDP_ST_BSY = 7;

	// =========================================================
	// reset values
	localparam logic [7:0] SIDP_WREG_RST   = 8'h00;
	localparam logic [7:0] SIDP_STATUS_RST = 8'h00;
	localparam logic [7:0] SIDP_MADDR_RST  = 8'h00;

	// =========================================================
	// operation codes written into the command register
	localparam logic [1:0] SIDP_OP_REG = 2'h1;
	localparam logic [1:0] SIDP_OP_MEM = 2'h2;
	localparam logic [1:0] SIDP_OP_IMM = 2'h3;

	// =========================================================
	// execution state
	typedef enum logic [1:0] {
		SIDP_IDLE,
		SIDP_EXEC,
		SIDP_DONE
	} sidp_state_t;

endpackage : sidp_pkg

// File: src/sidp_alu.sv
// eight-bit subtractor with flag generation
// assumes purely combinational use inside the datapath
`timescale 1ns/10ps
`default_nettype none

module sidp_alu
#(
	parameter int WIDTH = 8
)
(
	input  wire logic [WIDTH-1:0] minuend,
	input  wire logic [WIDTH-1:0] subtrahend,
	output var  logic [WIDTH-1:0] diff,
	output var  logic             carry,
	output var  logic             half_carry,
	output var  logic             zero,
	output var  logic             overflow
);

	logic [WIDTH:0] wide;
	logic [4:0]     low;

	// =========================================================
	// difference and flags
	always_comb
	begin
		wide       = {1'b0, minuend} - {1'b0, subtrahend};
		low        = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
		diff       = wide[WIDTH-1:0];
		carry      = ~wide[WIDTH];
		half_carry = ~low[4];
		zero       = (wide[WIDTH-1:0] == '0);
		overflow   = (minuend[WIDTH-1] != subtrahend[WIDTH-1])
			&& (wide[WIDTH-1] != minuend[WIDTH-1]);
	end

endmodule : sidp_alu

`default_nettype wire

// File: src/sidp_top.sv
// subtract datapath: working register, status flags, data memory
// assumes an avalon-mm master that holds requests until waitrequest low
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module sidp_top
	import sidp_pkg::*;
#(
	parameter int MEM_DEPTH = 160
)
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	output var  logic [7:0]  working_register,
	output var  logic        half_carry_bit,
	output var  logic        signed_range_error_bit
);

	sidp_state_t state;
	sidp_state_t next_state;
	logic [7:0]  status;
	logic [7:0]  next_status;
	logic [7:0]  next_working_register;
	logic [7:0]  maddr;
	logic [7:0]  next_maddr;
	logic [1:0]  op;
	logic [1:0]  next_op;
	logic [7:0]  imm;
	logic [7:0]  next_imm;
	logic [31:0] next_readdata;
	logic        next_waitrequest;
	logic [7:0]  mem [MEM_DEPTH];
	logic        mem_we;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic [7:0]  operand;
	logic [7:0]  diff;
	logic        f_c;
	logic        f_ac;
	logic        f_z;
	logic        f_ov;
	logic        addr_ok;
	logic        bus_req;

	// =========================================================
	// memory read port and operand select
	assign addr_ok  = (32'(maddr) < MEM_DEPTH);
	assign mem_rdata = addr_ok ? mem[maddr] : 8'h00;
	assign operand  = (op == SIDP_OP_IMM) ? imm : mem_rdata;
	assign bus_req  = avs_read | avs_write;

	sidp_alu #(
		.WIDTH      (8)
	) u_alu (
		.minuend    (working_register),
		.subtrahend (operand),
		.diff       (diff),
		.carry      (f_c),
		.half_carry (f_ac),
		.zero       (f_z),
		.overflow   (f_ov)
	);

	// =========================================================
	// next state, bus answer and execution
	always_comb
	begin
		next_state            = state;
		next_status           = status;
		next_working_register = working_register;
		next_maddr            = maddr;
		next_op               = op;
		next_imm              = imm;
		next_readdata         = avs_readdata;
		next_waitrequest      = 1'b1;
		mem_we                = 1'b0;
		mem_wdata             = 8'h00;
		unique case (state)
			SIDP_IDLE:
			begin
				if (bus_req)
				begin
					next_state = SIDP_EXEC;
				end
			end
			SIDP_EXEC:
			begin
				next_state       = SIDP_DONE;
				next_waitrequest = 1'b0;
				next_readdata    = 32'h0000_0000;
				if (avs_write)
				begin
					unique case (avs_address)
						SIDP_ADDR_CMD:
						begin
							next_op  = avs_writedata[SIDP_CMD_OP_LSB +: 2];
							next_imm = avs_writedata[SIDP_CMD_IMM_LSB +: 8];
						end
						SIDP_ADDR_WREG:
							next_working_register = avs_writedata[7:0];
						// busy bit stays hardware-owned, a write cannot start a run
						SIDP_ADDR_STATUS:
							next_status = {status[SIDP_ST_BSY],
								avs_writedata[6:0]};
						SIDP_ADDR_MADDR:
							next_maddr = avs_writedata[7:0];
						default:
							next_op = op;
					endcase
				end
				else
				begin
					unique case (avs_address)
						SIDP_ADDR_CMD:
							next_readdata = {22'h0, op, imm};
						SIDP_ADDR_WREG:
							next_readdata = {24'h0, working_register};
						SIDP_ADDR_STATUS:
							next_readdata = {24'h0, status};
						SIDP_ADDR_MADDR:
							next_readdata = {24'h0, mem_rdata};
						default:
							next_readdata = 32'h0000_0000;
					endcase
				end
				if (avs_write && avs_address == SIDP_ADDR_CMD
					&& avs_writedata[SIDP_CMD_OP_LSB +: 2] != 2'h0)
				begin
					next_status[SIDP_ST_BSY] = 1'b1;
				end
			end
			SIDP_DONE:
			begin
				next_state = SIDP_IDLE;
				if (status[SIDP_ST_BSY])
				begin
					next_status[SIDP_ST_BSY] = 1'b0;
					next_op                  = 2'h0;
					next_status[SIDP_ST_C]   = f_c;
					next_status[SIDP_ST_AC]  = f_ac;
					next_status[SIDP_ST_Z]   = f_z;
					next_status[SIDP_ST_OV]  = f_ov;
					if (op == SIDP_OP_MEM)
					begin
						mem_we    = addr_ok;
						mem_wdata = diff;
					end
					else
					begin
						next_working_register = diff;
					end
				end
			end
			default:
				next_state = SIDP_IDLE;
		endcase
	end

	// =========================================================
	// state registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state                  <= SIDP_IDLE;
			status                 <= SIDP_STATUS_RST;
			working_register       <= SIDP_WREG_RST;
			maddr                  <= SIDP_MADDR_RST;
			op                     <= 2'h0;
			imm                    <= 8'h00;
			avs_readdata           <= 32'h0000_0000;
			avs_waitrequest        <= 1'b1;
			half_carry_bit         <= 1'b0;
			signed_range_error_bit <= 1'b0;
		end
		else
		begin
			state                  <= next_state;
			status                 <= next_status;
			working_register       <= next_working_register;
			maddr                  <= next_maddr;
			op                     <= next_op;
			imm                    <= next_imm;
			avs_readdata           <= next_readdata;
			avs_waitrequest        <= next_waitrequest;
			half_carry_bit         <= next_status[SIDP_ST_AC];
			signed_range_error_bit <= next_status[SIDP_ST_OV];
		end
	end

	// =========================================================
	// data memory, cleared by reset so operands are known
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < MEM_DEPTH; i++)
			begin
				mem[i] <= 8'h00;
			end
		end
		else if (mem_we)
		begin
			mem[maddr] <= mem_wdata;
		end
	end

endmodule : sidp_top

`default_nettype wire

// File: bench/sidp_top_asserts.sv
// checker for the subtract datapath bus and result ports
// assumes it is bound onto sidp_top
`timescale 1ns/10ps
`default_nettype none
module sidp_top_chk
	import sidp_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [7:0]  working_register,
	input wire logic        half_carry_bit,
	input wire logic        signed_range_error_bit
);
	// ====
	// answered write and command decode
	wire logic wa = avs_write && !avs_waitrequest;
	wire logic cm = wa && avs_address == SIDP_ADDR_CMD;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_answer_time: assert property ((avs_read || avs_write) |-> ##[0:4]
		!avs_waitrequest) else $error("request not answered");
	chk_w_cause: assert property ($changed(working_register) |->
		wa || $past(wa)) else $error("w changed alone");
	chk_hc_cause: assert property ($changed(half_carry_bit) |->
		wa || $past(wa)) else $error("hc changed alone");
	chk_ov_cause: assert property (
		$changed(signed_range_error_bit) |-> wa || $past(wa))
		else $error("ov changed alone");
	chk_imm_result: assert property (
		cm && avs_writedata[9:8] == SIDP_OP_IMM |-> ##1 working_register ==
		$past(working_register) - $past(avs_writedata[7:0]))
		else $error("immediate result wrong");
	chk_mem_keeps_w: assert property (
		cm && avs_writedata[9:8] == SIDP_OP_MEM |-> ##1
		$stable(working_register)) else $error("w changed on write-back");
	chk_upper_zero: assert property (avs_read && !avs_waitrequest |->
		avs_readdata[31:10] == 22'h0) else $error("upper read bits set");
endmodule : sidp_top_chk
bind sidp_top sidp_top_chk u_chk (.clk(clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .working_register(working_register),
	.half_carry_bit(half_carry_bit),
	.signed_range_error_bit(signed_range_error_bit));
`default_nettype wire

// File: bench/sidp_top_tb_top.sv
// self-checking bench for the subtract datapath
// assumes the bench is the only avalon master
`timescale 1ns/10ps
`default_nettype none
module sidp_top_tb_top
	import sidp_pkg::*;
;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic        avs_waitrequest, half_carry_bit, signed_range_error_bit;
	logic [7:0]  working_register;
	int          err_total = 0;
	int          samples_checked = 0;
	// rows: working register, immediate, result, status
	logic [31:0] rows [6] = '{32'h0503_0273, 32'h0305_FE70,
		32'h8001_7F79, 32'h1001_0F71, 32'h4242_0077, 32'h7FFF_807A};
	always #10 clk = ~clk;
	sidp_top #(.MEM_DEPTH(160)) uut (.clk(clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.working_register(working_register), .half_carry_bit(half_carry_bit),
		.signed_range_error_bit(signed_range_error_bit));
	// ====
	// bus cycle, compare, verdict
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0)
		begin
			err_total++;
			give_verdict();
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : bus
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
			err_total++;
		end
	endtask : chk
	task give_verdict;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		#100000;
		err_total++;
		give_verdict();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i])
		begin
			bus(1'b1, SIDP_ADDR_WREG, {24'h0, rows[i][31:24]});
			bus(1'b1, SIDP_ADDR_STATUS, 32'h70);
			bus(1'b1, SIDP_ADDR_CMD, {22'h0, SIDP_OP_IMM, rows[i][23:16]});
			bus(1'b0, SIDP_ADDR_WREG, 32'h0);
			chk(q, {24'h0, rows[i][15:8]});
			bus(1'b0, SIDP_ADDR_STATUS, 32'h0);
			chk(q, {24'h0, rows[i][7:0]});
			chk({31'h0, half_carry_bit}, {31'h0, rows[i][1]});
			chk({31'h0, signed_range_error_bit}, {31'h0, rows[i][3]});
		end
		// command reads back op cleared, last immediate kept
		bus(1'b0, SIDP_ADDR_CMD, 32'h0);
		chk(q, 32'h0000_00FF);
		// memory forms on a cleared byte inside memory
		bus(1'b1, SIDP_ADDR_MADDR, 32'h10);
		bus(1'b1, SIDP_ADDR_WREG, 32'h5A);
		bus(1'b1, SIDP_ADDR_CMD, {22'h0, SIDP_OP_MEM, 8'h00});
		chk({24'h0, working_register}, 32'h5A);
		bus(1'b0, SIDP_ADDR_MADDR, 32'h0);
		chk(q, 32'h5A);
		bus(1'b1, SIDP_ADDR_WREG, 32'h30);
		bus(1'b1, SIDP_ADDR_CMD, {22'h0, SIDP_OP_REG, 8'h00});
		bus(1'b0, SIDP_ADDR_WREG, 32'h0);
		chk(q, 32'hD6);
		bus(1'b0, SIDP_ADDR_STATUS, 32'h0);
		chk(q, 32'h70);
		bus(1'b1, SIDP_ADDR_CMD, {22'h0, SIDP_OP_MEM, 8'h00});
		bus(1'b0, SIDP_ADDR_MADDR, 32'h0);
		chk(q, 32'h7C);
		bus(1'b0, SIDP_ADDR_STATUS, 32'h0);
		chk(q, 32'h79);
		chk({24'h0, working_register}, 32'hD6);
		chk({31'h0, signed_range_error_bit}, 32'h1);
		// address outside memory, operand reads 0
		bus(1'b1, SIDP_ADDR_MADDR, 32'hC8);
		bus(1'b1, SIDP_ADDR_CMD, {22'h0, SIDP_OP_REG, 8'h00});
		bus(1'b0, SIDP_ADDR_STATUS, 32'h0);
		chk(q, 32'h73);
		bus(1'b0, SIDP_ADDR_MADDR, 32'h0);
		chk(q, 32'h0);
		// unmapped address ignored, reads zero
		bus(1'b1, 4'h2, 32'hFF);
		bus(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		chk({24'h0, working_register}, 32'hD6);
		// busy bit write and op 0 run nothing
		bus(1'b1, SIDP_ADDR_STATUS, 32'hFF);
		bus(1'b1, SIDP_ADDR_CMD, 32'h11);
		bus(1'b0, SIDP_ADDR_CMD, 32'h0);
		chk(q, 32'h11);
		bus(1'b0, SIDP_ADDR_STATUS, 32'h0);
		chk(q, 32'h7F);
		chk({24'h0, working_register}, 32'hD6);
		// second reset with the datapath idle, after the last bus cycle
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk({24'h0, working_register}, 32'h0);
		chk({31'h0, avs_waitrequest}, 32'h1);
		bus(1'b0, SIDP_ADDR_STATUS, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, SIDP_ADDR_MADDR, 32'h0);
		chk(q, 32'h0);
		give_verdict();
	end
endmodule : sidp_top_tb_top
`default_nettype wire
